/* cdso_defines.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef CDSO_DEFINES_SVH
`define CDSO_DEFINES_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define CDSO_GENERAL_SETUP_OFS 8'h11
`define CDSO_CLOCK_SYNTH_OFS 8'h12
`define CDSO_SUPPLY_OK_OFS 8'h13
`define CDSO_IRQ_STATUS_OFS 8'h20
`define CDSO_IRQ_MASK_OFS 8'h21
`define CDSO_STATUS_OFS 8'h22

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CDSO_SYNTH_EN_BIT 6
`define CDSO_FRAC_DIV_BIT 5
`define CDSO_RATE_MAX 5'h17
`define CDSO_IRQ_CLK_UP 0
`define CDSO_IRQ_CLK_DOWN 1
`define CDSO_IRQ_SOK_CHANGE 2
`define CDSO_IRQ_FRAC_WRITE 3

// ----------------------------------------------------------------
// Reset values used until the programmable defaults are loaded
// ----------------------------------------------------------------
`define CDSO_GENERAL_SETUP_RST 8'h3c
`define CDSO_CLOCK_SYNTH_RST 8'h02
`define CDSO_SUPPLY_OK_RST 8'h00

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CDSO_CLK_PERIOD_NS 10
`define CDSO_FINE_STEP_US 500
`define CDSO_COARSE_STEP_US 1000
`define CDSO_FINE_STEP_CYC ((`CDSO_FINE_STEP_US * 1000) / `CDSO_CLK_PERIOD_NS)
`define CDSO_COARSE_STEP_CYC \
    ((`CDSO_COARSE_STEP_US * 1000) / `CDSO_CLK_PERIOD_NS)

`endif

/* cdso_pkg.sv */
// Types shared by the configuration block
package cdso_pkg;
    typedef struct packed {
        logic startupCoarse;
        logic shutdownCoarse;
        logic extClockPulldownEnable;
        logic thirdEnablePinPulldown;
        logic secondEnablePinPulldown;
        logic firstEnablePinPulldown;
        logic thermalWarningSelect;
        logic spreadModulationEnable;
    } cdso_setup_type;

    typedef struct packed {
        logic reserved;
        logic synthEnable;
        logic fractionalDividerEnable;
        logic [4:0] externalClockRateCode;
    } cdso_synth_type;

    typedef struct packed {
        logic reserved;
        logic supplyOkMethod;
        logic analogSupplyOkEnable;
        logic secondMonitorOkEnable;
        logic firstMonitorOkEnable;
        logic stepUpOkEnable;
        logic secondStepDownOkEnable;
        logic firstStepDownOkEnable;
    } cdso_supply_type;

    typedef enum logic [1:0] {
        CDSO_IDLE = 2'b00,
        CDSO_COUNT = 2'b01,
        CDSO_DONE = 2'b11
    } cdso_delay_state_type;
endpackage

/* cdso_delay_if.sv */
// Request and answer between top and one delay timer
`timescale 1ns/1ns
`default_nettype none
interface cdso_delay_if;
    logic start;
    logic coarse;
    logic [3:0] code;
    logic done;
    modport top (output start, output coarse, output code, input done);
    modport timer (input start, input coarse, input code, output done);
endinterface
`default_nettype wire

/* cdso_delay_timer.sv */
// One start-up or shutdown delay timer scaled by a step select
`timescale 1ns/1ns
`default_nettype none
`include "cdso_defines.svh"
module cdso_delay_timer (
    input wire logic clk,
    input wire logic arst_n,
    cdso_delay_if.timer req
);
    import cdso_pkg::*;

    typedef struct packed {
        cdso_delay_state_type state;
        logic [3:0] steps;
        logic [16:0] tick;
        logic stepCoarse;
    } cdso_timer_state_type;

    cdso_timer_state_type cur;
    cdso_timer_state_type nxt;
    logic [16:0] stepLast;

    always_comb begin
        nxt = cur;
        stepLast = cur.stepCoarse ? 17'(`CDSO_COARSE_STEP_CYC - 1)
                                  : 17'(`CDSO_FINE_STEP_CYC - 1);
        case (cur.state)
            CDSO_IDLE: begin
                if (req.start) begin
                    nxt.steps = req.code;
                    nxt.stepCoarse = req.coarse;
                    nxt.tick = 17'h0;
                    // Code zero means no delay
                    nxt.state = (req.code == 4'h0) ? CDSO_DONE
                                                   : CDSO_COUNT;
                end
            end
            CDSO_COUNT: begin
                if (cur.tick == stepLast) begin
                    nxt.tick = 17'h0;
                    nxt.steps = cur.steps - 4'h1;
                    if (cur.steps == 4'h1) begin
                        nxt.state = CDSO_DONE;
                    end
                end else begin
                    nxt.tick = cur.tick + 17'h1;
                end
            end
            CDSO_DONE: begin
                nxt.state = CDSO_IDLE;
            end
            default: begin
                nxt.state = CDSO_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cur <= '0;
        end else begin
            cur <= nxt;
        end
    end

    assign req.done = (cur.state == CDSO_DONE);

    done_zero_a: assert property (@(posedge clk) disable iff (!arst_n)
        (cur.state == CDSO_IDLE && req.start && req.code == 4'h0)
        |=> req.done) else $error("zero code delay not immediate");
endmodule
`default_nettype wire

/* cdso_config.sv */
// Clock, delay and supply-ok configuration register bank
`timescale 1ns/1ns
`default_nettype none
`include "cdso_defines.svh"
// What this block does
// - Start-up step select picks 0.5 ms or 1 ms steps for start-up codes.
// - Shutdown step select picks 0.5 ms or 1 ms steps for shutdown codes.
// - Setup bit 5 drives the external clock input pull-down.
// - Setup bits 4..2 drive the third, second, first enable pin pull-downs.
// - Thermal warning select picks 125C when clear, 140C when set.
// - Setup bit 0 turns converter spread modulation on.
// - Setup, synthesizer and supply-ok defaults are loaded from programmable memory; the interrupt mask resets to zero.
// - Synthesizer off forces internal oscillator, PLL disabled.
// - Synthesizer on runs PLL in standby/active; external clock when valid.
// - Synthesizer on: clock appearing or vanishing raises an interrupt.
// - Rate code is MHz minus one, up to 0x17; higher codes reserved.
// - Supply-ok control bit 6 selects undervoltage or window monitoring.
// - Supply-ok bits 5..0 enable diagnostics per monitored source.
// - Method or enable change during operation may raise an interrupt.
// - Delay equals code times step; zero is none, all ones maximum.
module cdso_config (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdata,
    output logic irq,
    input wire logic otpValid,
    input wire logic [7:0] otpGeneralSetup,
    input wire logic [7:0] otpClockSynth,
    input wire logic [7:0] otpSupplyOk,
    input wire logic deviceActive,
    input wire logic extClockValid,
    input wire logic startupRequest,
    input wire logic [3:0] startupCode,
    output logic startupDone,
    input wire logic shutdownRequest,
    input wire logic [3:0] shutdownCode,
    output logic shutdownDone,
    output logic extClockPulldownEnable,
    output logic thirdEnablePinPulldown,
    output logic secondEnablePinPulldown,
    output logic firstEnablePinPulldown,
    output logic thermalWarningSelect,
    output logic spreadModulationEnable,
    output logic pllEnable,
    output logic useExternalClock,
    output logic [4:0] externalClockRateCode,
    output logic rateCodeReserved,
    output logic supplyOkMethod,
    output logic [5:0] supplyOkEnables
);
    import cdso_pkg::*;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        cdso_setup_type setup;
        cdso_synth_type synth;
        cdso_supply_type supply;
        logic [3:0] irqStatus;
        logic [3:0] irqMask;
        logic loaded;
        logic clockSeen;
        logic [7:0] rdata;
    } cdso_cfg_state_type;

    cdso_cfg_state_type cur;
    cdso_cfg_state_type nxt;
    logic [3:0] events;
    logic [7:0] readMux;

    cdso_delay_if upIf ();
    cdso_delay_if downIf ();

    // ----------------------------------------------------------------
    // Delay timers
    // ----------------------------------------------------------------
    assign upIf.start = startupRequest;
    assign upIf.coarse = cur.setup.startupCoarse;
    assign upIf.code = startupCode;
    assign startupDone = upIf.done;
    assign downIf.start = shutdownRequest;
    assign downIf.coarse = cur.setup.shutdownCoarse;
    assign downIf.code = shutdownCode;
    assign shutdownDone = downIf.done;

    cdso_delay_timer startupTimer (
        .clk(clk),
        .arst_n(arst_n),
        .req(upIf.timer)
    );

    cdso_delay_timer shutdownTimer (
        .clk(clk),
        .arst_n(arst_n),
        .req(downIf.timer)
    );

    // ----------------------------------------------------------------
    // Register file
    // ----------------------------------------------------------------
    always_comb begin
        case (regAddr)
            `CDSO_GENERAL_SETUP_OFS: readMux = cur.setup;
            `CDSO_CLOCK_SYNTH_OFS: readMux = cur.synth;
            `CDSO_SUPPLY_OK_OFS: readMux = cur.supply;
            `CDSO_IRQ_STATUS_OFS: readMux = {4'h0, cur.irqStatus};
            `CDSO_IRQ_MASK_OFS: readMux = {4'h0, cur.irqMask};
            `CDSO_STATUS_OFS: readMux = {5'h0, rateCodeReserved,
                                          useExternalClock, cur.loaded};
            default: readMux = 8'h00;
        endcase
    end

    always_comb begin
        nxt = cur;
        events = 4'h0;
        nxt.rdata = regRead ? readMux : 8'h00;
        // Load the programmed defaults once after reset release
        if (!cur.loaded && otpValid) begin
            nxt.setup = otpGeneralSetup;
            nxt.synth = otpClockSynth;
            nxt.supply = otpSupplyOk;
            nxt.loaded = 1'b1;
        end else if (regWrite) begin
            case (regAddr)
                `CDSO_GENERAL_SETUP_OFS: nxt.setup = regWdata;
                `CDSO_CLOCK_SYNTH_OFS: begin
                    nxt.synth = regWdata;
                    // Writing one here is a software error; flag it
                    if (regWdata[`CDSO_FRAC_DIV_BIT]) begin
                        events[`CDSO_IRQ_FRAC_WRITE] = 1'b1;
                    end
                end
                `CDSO_SUPPLY_OK_OFS: begin
                    nxt.supply = regWdata;
                    if (deviceActive && (regWdata[6:0] != cur.supply[6:0]))
                    begin
                        events[`CDSO_IRQ_SOK_CHANGE] = 1'b1;
                    end
                end
                `CDSO_IRQ_MASK_OFS: nxt.irqMask = regWdata[3:0];
                default: begin
                end
            endcase
        end
        nxt.clockSeen = pllEnable && extClockValid;
        if (pllEnable && extClockValid && !cur.clockSeen) begin
            events[`CDSO_IRQ_CLK_UP] = 1'b1;
        end
        if (pllEnable && !extClockValid && cur.clockSeen) begin
            events[`CDSO_IRQ_CLK_DOWN] = 1'b1;
        end
        // Set wins over a write-one clear in the same cycle
        if (regWrite && regAddr == `CDSO_IRQ_STATUS_OFS) begin
            nxt.irqStatus = cur.irqStatus & ~regWdata[3:0];
        end
        nxt.irqStatus = nxt.irqStatus | events;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cur.setup <= `CDSO_GENERAL_SETUP_RST;
            cur.synth <= `CDSO_CLOCK_SYNTH_RST;
            cur.supply <= `CDSO_SUPPLY_OK_RST;
            cur.irqStatus <= 4'h0;
            cur.irqMask <= 4'h0;
            cur.loaded <= 1'b0;
            cur.clockSeen <= 1'b0;
            cur.rdata <= 8'h00;
        end else begin
            cur <= nxt;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign regRdata = cur.rdata;
    assign irq = |(cur.irqStatus & cur.irqMask);
    assign extClockPulldownEnable = cur.setup.extClockPulldownEnable;
    assign thirdEnablePinPulldown = cur.setup.thirdEnablePinPulldown;
    assign secondEnablePinPulldown =
        cur.setup.secondEnablePinPulldown;
    assign firstEnablePinPulldown = cur.setup.firstEnablePinPulldown;
    assign thermalWarningSelect = cur.setup.thermalWarningSelect;
    assign spreadModulationEnable = cur.setup.spreadModulationEnable;
    // PLL runs only in standby or active while enabled
    assign pllEnable = cur.synth.synthEnable && deviceActive;
    assign useExternalClock = pllEnable && extClockValid;
    assign externalClockRateCode = cur.synth.externalClockRateCode;
    assign rateCodeReserved =
        cur.synth.externalClockRateCode > `CDSO_RATE_MAX;
    assign supplyOkMethod = cur.supply.supplyOkMethod;
    assign supplyOkEnables = cur.supply[5:0];

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence clkAppears;
        pllEnable && extClockValid && !cur.clockSeen;
    endsequence

    sequence clkVanishes;
        pllEnable && !extClockValid && cur.clockSeen;
    endsequence

    pll_off_a: assert property (@(posedge clk) disable iff (!arst_n)
        !cur.synth.synthEnable |-> !pllEnable && !useExternalClock)
        else $error("PLL active while disabled");
    ext_clock_a: assert property (@(posedge clk) disable iff (!arst_n)
        (cur.synth.synthEnable && deviceActive && extClockValid)
        |-> useExternalClock) else $error("external clock not used");
    clk_up_irq_a: assert property (@(posedge clk) disable iff (!arst_n)
        clkAppears |=> cur.irqStatus[`CDSO_IRQ_CLK_UP])
        else $error("clock appear event lost");
    clk_down_irq_a: assert property (@(posedge clk) disable iff (!arst_n)
        clkVanishes |=> cur.irqStatus[`CDSO_IRQ_CLK_DOWN])
        else $error("clock vanish event lost");
    otp_load_a: assert property (@(posedge clk) disable iff (!arst_n)
        (!cur.loaded && otpValid) |=> (cur.setup == $past(otpGeneralSetup))
        && (cur.synth == $past(otpClockSynth)) && cur.loaded)
        else $error("defaults not loaded");
    setup_pins_a: assert property (@(posedge clk) disable iff (!arst_n)
        (cur.loaded && regWrite && regAddr == `CDSO_GENERAL_SETUP_OFS)
        |=> {extClockPulldownEnable, thirdEnablePinPulldown,
             secondEnablePinPulldown, firstEnablePinPulldown,
             thermalWarningSelect, spreadModulationEnable}
            == $past(regWdata[5:0]))
        else $error("setup bits not applied");
    supply_write_a: assert property (@(posedge clk) disable iff (!arst_n)
        (cur.loaded && regWrite && regAddr == `CDSO_SUPPLY_OK_OFS)
        |=> {supplyOkMethod, supplyOkEnables} == $past(regWdata[6:0]))
        else $error("supply-ok bits not applied");
    sok_irq_a: assert property (@(posedge clk) disable iff (!arst_n)
        (cur.loaded && deviceActive && regWrite
         && regAddr == `CDSO_SUPPLY_OK_OFS
         && regWdata[6:0] != cur.supply[6:0])
        |=> cur.irqStatus[`CDSO_IRQ_SOK_CHANGE])
        else $error("supply-ok change not flagged");
    reserved_rd_a: assert property (@(posedge clk) disable iff (!arst_n)
        (regRead && regAddr == `CDSO_CLOCK_SYNTH_OFS)
        |=> regRdata[7] == $past(cur.synth.reserved))
        else $error("reserved bit not read back");
    rate_rsv_a: assert property (@(posedge clk) disable iff (!arst_n)
        rateCodeReserved == (externalClockRateCode >= 5'h18))
        else $error("rate code range wrong");
endmodule
`default_nettype wire

/* cdso_config_test.sv */
// Self-checking testbench for the configuration register bank
`timescale 1ns/1ns
`default_nettype none
`include "cdso_defines.svh"
`define CHK(g, e) check(32'(g), 32'(e))
module cdso_config_test;
    import cdso_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic clk, arst_n, regWrite, regRead, otpValid, irq;
    logic [7:0] regAddr, regWdata, regRdata;
    logic [7:0] otpGeneralSetup, otpClockSynth, otpSupplyOk;
    logic deviceActive, extClockValid, startupRequest, shutdownRequest;
    logic [3:0] startupCode, shutdownCode;
    logic startupDone, shutdownDone, extClockPulldownEnable;
    logic thirdEnablePinPulldown, secondEnablePinPulldown;
    logic firstEnablePinPulldown, thermalWarningSelect;
    logic spreadModulationEnable, pllEnable, useExternalClock;
    logic [4:0] externalClockRateCode;
    logic rateCodeReserved, supplyOkMethod;
    logic [5:0] supplyOkEnables;
    logic [7:0] setupNow, synthNow, supplyNow;
    logic [31:0] rdQ[$], suQ[$], sdQ[$];
    int miscompares, totalChecks, suSince, sdSince;
    bit rdLast;
    integer seed = 32'hbdcf;

    cdso_config i_cdso_config (
        .clk, .arst_n, .regAddr, .regWdata, .regWrite, .regRead, .regRdata,
        .irq, .otpValid, .otpGeneralSetup, .otpClockSynth, .otpSupplyOk,
        .deviceActive, .extClockValid, .startupRequest, .startupCode,
        .startupDone, .shutdownRequest, .shutdownCode, .shutdownDone,
        .extClockPulldownEnable, .thirdEnablePinPulldown,
        .secondEnablePinPulldown, .firstEnablePinPulldown,
        .thermalWarningSelect, .spreadModulationEnable, .pllEnable,
        .useExternalClock, .externalClockRateCode, .rateCodeReserved,
        .supplyOkMethod, .supplyOkEnables
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] g, input logic [31:0] e);
        totalChecks++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic finalReport;
        $display("checks=%0d mismatches=%0d", totalChecks, miscompares);
        if (miscompares == 0 && totalChecks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // One bus cycle per call; op 0 idle, 1 write, 2 read (d is expected)
    task automatic bus(input int op, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        regWrite <= (op == 1);
        regRead <= (op == 2);
        regAddr <= a;
        regWdata <= d;
        if (op == 2) rdQ.push_back(32'(d));
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1, a, d);
        if (a == `CDSO_GENERAL_SETUP_OFS) setupNow = d;
        if (a == `CDSO_CLOCK_SYNTH_OFS) synthNow = d;
        if (a == `CDSO_SUPPLY_OK_OFS) supplyNow = d;
    endtask

    task automatic settle;
        bus(0, 8'h00, 8'h00);
        @(negedge clk);
    endtask

    task automatic waitIrq(input logic e);
        for (int i = 0; i < 8 && irq !== e; i++) @(negedge clk);
        `CHK(irq, e);
    endtask

    task automatic checkAll;
        bus(2, `CDSO_GENERAL_SETUP_OFS, setupNow);
        bus(2, `CDSO_CLOCK_SYNTH_OFS, synthNow);
        bus(2, `CDSO_SUPPLY_OK_OFS, supplyNow);
        settle;
        `CHK(extClockPulldownEnable, setupNow[5]);
        `CHK({thirdEnablePinPulldown, secondEnablePinPulldown,
              firstEnablePinPulldown}, setupNow[4:2]);
        `CHK(thermalWarningSelect, setupNow[1]);
        `CHK(spreadModulationEnable, setupNow[0]);
        `CHK(pllEnable, synthNow[6] & deviceActive);
        `CHK(useExternalClock,
             synthNow[6] & deviceActive & extClockValid);
        `CHK(externalClockRateCode, synthNow[4:0]);
        `CHK(rateCodeReserved, synthNow[4:0] > 5'h17);
        `CHK(supplyOkMethod, supplyNow[6]);
        `CHK(supplyOkEnables, supplyNow[5:0]);
    endtask

    // Step select is sampled with the request, so expectation uses it now
    task automatic req(input bit su, input logic [3:0] c);
        int step = (su ? setupNow[7] : setupNow[6]) ?
                   `CDSO_COARSE_STEP_CYC : `CDSO_FINE_STEP_CYC;
        int n = c * step + 1;
        @(posedge clk);
        {regWrite, regRead} <= 2'b00;
        if (su) begin
            startupRequest <= 1'b1;
            startupCode <= c;
            suQ.push_back(32'(n));
        end else begin
            shutdownRequest <= 1'b1;
            shutdownCode <= c;
            sdQ.push_back(32'(n));
        end
        @(posedge clk);
        {startupRequest, shutdownRequest} <= 2'b00;
        for (int i = 0; i < n + 10 && suQ.size() + sdQ.size() > 0; i++) begin
            @(posedge clk);
        end
    endtask

    // ------------------------------------------------------------
    // Result watcher: read data and delay completions
    // ------------------------------------------------------------
    always @(posedge clk) begin
        // Read data is only meaningful once reset has settled
        if (rdLast && arst_n === 1'b1) begin
            `CHK(regRdata, rdQ.pop_front());
        end else if (arst_n === 1'b1) begin
            `CHK(regRdata, 8'h00);
        end
        rdLast = regRead;
        suSince = startupRequest ? 0 : suSince + 1;
        sdSince = shutdownRequest ? 0 : sdSince + 1;
        if (startupDone === 1'b1) `CHK(suSince, suQ.pop_front());
        // A done with nothing pending expects zero, which no real delay gives
        if (shutdownDone === 1'b1) begin
            `CHK(sdSince, sdQ.size() ? sdQ.pop_front() : 32'h0);
        end
    end

    // Whole run is about 50000 cycles, dominated by one 0.5 ms delay
    initial begin
        repeat (80000) @(posedge clk);
        miscompares++;
        finalReport;
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [7:0] v;
        arst_n = 1'b0;
        {regWrite, regRead, otpValid, deviceActive, extClockValid} = 5'h00;
        {startupRequest, shutdownRequest, startupCode, shutdownCode} = 10'h0;
        regAddr = 8'h00;
        regWdata = 8'h00;
        otpGeneralSetup = 8'($random(seed));
        otpClockSynth = 8'($random(seed));
        otpSupplyOk = 8'($random(seed));
        setupNow = `CDSO_GENERAL_SETUP_RST;
        synthNow = `CDSO_CLOCK_SYNTH_RST;
        supplyNow = `CDSO_SUPPLY_OK_RST;
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        // A write before the programmed defaults arrive still lands
        wr(`CDSO_GENERAL_SETUP_OFS, 8'h00);
        checkAll;
        bus(2, `CDSO_STATUS_OFS, 8'h00);
        otpValid <= 1'b1;
        settle;
        setupNow = otpGeneralSetup;
        synthNow = otpClockSynth;
        supplyNow = otpSupplyOk;
        checkAll;
        bus(2, `CDSO_STATUS_OFS, {5'h00, synthNow[4:0] > 5'h17, 2'b01});
        for (int i = 0; i < 16; i++) begin
            v = (i == 0) ? 8'h17 : (i == 1) ? 8'hd8 : 8'($random(seed));
            wr(`CDSO_GENERAL_SETUP_OFS, 8'($random(seed)));
            deviceActive <= 1'($random(seed));
            extClockValid <= 1'($random(seed));
            wr(`CDSO_CLOCK_SYNTH_OFS, synthNow & 8'h9f);
            wr(`CDSO_CLOCK_SYNTH_OFS, v & 8'hdf);
            wr(`CDSO_SUPPLY_OK_OFS, 8'($random(seed)));
            checkAll;
        end
        // Clock presence events with the synthesizer on
        bus(1, `CDSO_IRQ_STATUS_OFS, 8'h0f);
        deviceActive <= 1'b1;
        extClockValid <= 1'b0;
        wr(`CDSO_CLOCK_SYNTH_OFS, synthNow & 8'h9f);
        wr(`CDSO_CLOCK_SYNTH_OFS, 8'h02);
        wr(`CDSO_CLOCK_SYNTH_OFS, 8'h42);
        bus(1, `CDSO_IRQ_STATUS_OFS, 8'h0f);
        bus(1, `CDSO_IRQ_MASK_OFS, 8'h0f);
        settle;
        waitIrq(1'b0);
        bus(0, 8'h00, 8'h00);
        extClockValid <= 1'b1;
        settle;
        waitIrq(1'b1);
        checkAll;
        bus(2, `CDSO_IRQ_STATUS_OFS, 8'h01);
        bus(2, `CDSO_STATUS_OFS, 8'h03);
        bus(1, `CDSO_IRQ_STATUS_OFS, 8'h01);
        settle;
        waitIrq(1'b0);
        bus(0, 8'h00, 8'h00);
        extClockValid <= 1'b0;
        settle;
        waitIrq(1'b1);
        bus(2, `CDSO_IRQ_STATUS_OFS, 8'h02);
        bus(1, `CDSO_IRQ_STATUS_OFS, 8'h02);
        // Synthesizer off: no clock events, internal oscillator only
        wr(`CDSO_CLOCK_SYNTH_OFS, 8'h02);
        bus(0, 8'h00, 8'h00);
        extClockValid <= 1'b1;
        checkAll;
        bus(2, `CDSO_IRQ_STATUS_OFS, 8'h00);
        // Deliberate one in the fractional divider bit is flagged
        wr(`CDSO_CLOCK_SYNTH_OFS, 8'h22);
        settle;
        waitIrq(1'b1);
        bus(2, `CDSO_IRQ_STATUS_OFS, 8'h08);
        bus(1, `CDSO_IRQ_STATUS_OFS, 8'h08);
        wr(`CDSO_CLOCK_SYNTH_OFS, 8'h02);
        // Supply-ok change while active: held masked, then unmasked
        bus(1, `CDSO_IRQ_MASK_OFS, 8'h00);
        wr(`CDSO_SUPPLY_OK_OFS, supplyNow ^ 8'h40);
        bus(2, `CDSO_IRQ_STATUS_OFS, 8'h04);
        settle;
        `CHK(irq, 1'b0);
        bus(1, `CDSO_IRQ_MASK_OFS, 8'h04);
        settle;
        waitIrq(1'b1);
        bus(1, `CDSO_IRQ_STATUS_OFS, 8'h04);
        settle;
        waitIrq(1'b0);
        // Unmapped place and the narrow mask register
        bus(1, 8'h30, 8'hff);
        bus(2, 8'h30, 8'h00);
        bus(1, `CDSO_IRQ_MASK_OFS, 8'hff);
        bus(2, `CDSO_IRQ_MASK_OFS, 8'h0f);
        // Delay timers, back to back after each completion
        wr(`CDSO_GENERAL_SETUP_OFS, 8'h40);
        req(1'b1, 4'h0);
        req(1'b0, 4'h0);
        // Coarse shutdown step must outlast a fine start-up step
        @(posedge clk);
        {regWrite, regRead} <= 2'b00;
        shutdownRequest <= 1'b1;
        shutdownCode <= 4'h1;
        req(1'b1, 4'h1);
        repeat (4) @(posedge clk);
        `CHK(shutdownDone, 1'b0);
        // Reset in mid-run cuts the long delay and reloads the defaults
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        setupNow = otpGeneralSetup;
        synthNow = otpClockSynth;
        supplyNow = otpSupplyOk;
        checkAll;
        req(1'b0, 4'h0);
        settle;
        `CHK(rdQ.size() + suQ.size() + sdQ.size(), 0);
        finalReport;
    end
endmodule
`default_nettype wire
